//--- logic/regbank_pkg.sv
// Register map, reset values, field positions and slew timing of the converter register bank.
package regbank_pkg;
    // ========================================================================
    // Register offsets
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h01;
    localparam logic [7:0] OFS_VSEL = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h03;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SETTINGS = 8'h05;
    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h0a;
    localparam logic [7:0] RST_VSEL = 8'h28;
    localparam logic [7:0] RST_CTRL = 8'h0a;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_SETTINGS = 8'ha4;
    // Arbitrary identity value, not any real maker's code.
    localparam logic [7:0] IDENT_DEFAULT = 8'h5a;
    // ========================================================================
    // Field positions and masks
    localparam int SLEW_LSB = 2;
    localparam int FREQ_LSB = 0;
    localparam logic [7:0] CONFIG_WMASK = 8'h0f;
    localparam logic [7:0] VSEL_WMASK = 8'h7f;
    // ========================================================================
    // Slew timing: one 10 mV code step per interval, 10 MHz clock.
    localparam int CLK_MHZ = 10;
    localparam int STEP_MV = 10;
    localparam int SLEW20_MV_US = 20;
    localparam int SLEW15_MV_US = 15;
    localparam int SLEW10_MV_US = 10;
    localparam int SLEW5_MV_US = 5;
    // Interval in cycles = step / rate * clock rate, rounded down, so never longer than the exact time.
    localparam int STEP20_CYC = STEP_MV * CLK_MHZ / SLEW20_MV_US;
    localparam int STEP15_CYC = STEP_MV * CLK_MHZ / SLEW15_MV_US;
    localparam int STEP10_CYC = STEP_MV * CLK_MHZ / SLEW10_MV_US;
    localparam int STEP5_CYC = STEP_MV * CLK_MHZ / SLEW5_MV_US;
    // Switching frequency codes in 100 kHz units.
    localparam logic [3:0] FSW_CODE0 = 4'h6;
    localparam logic [3:0] FSW_CODE1 = 4'h8;
    localparam logic [3:0] FSW_CODE2 = 4'ha;
    localparam logic [3:0] FSW_CODE3 = 4'hf;
    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_UP = 2'b01,
        RAMP_DOWN = 2'b10
    } ramp_state_t;
endpackage

//--- logic/vid_ramp.sv
// Stepper that moves the voltage target towards the selected code at a chosen rate.
`timescale 1ns/100ps
module vid_ramp #(
    parameter int CODE_W = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic [CODE_W-1:0] resetCode,
    input wire logic [CODE_W-1:0] goalCode,
    input wire logic [7:0] stepCycles,
    // Result
    output logic [CODE_W-1:0] targetCode,
    output logic ramping
);
    regbank_pkg::ramp_state_t state_q, state_d;
    logic [CODE_W-1:0] target_q;
    logic [7:0] timer_q;
    logic primed_q;
    wire logic tick = (timer_q + 8'h01 >= stepCycles);
    wire logic above = goalCode > target_q;
    wire logic below = goalCode < target_q;

    always_comb begin
        case ({above, below})
            2'b10: state_d = regbank_pkg::RAMP_UP;
            2'b01: state_d = regbank_pkg::RAMP_DOWN;
            default: state_d = regbank_pkg::RAMP_IDLE;
        endcase
    end

    // ========================================================================
    // Target stepping
    // Rate-limited stepping.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= regbank_pkg::RAMP_IDLE;
            target_q <= '0;
            timer_q <= 8'h00;
            primed_q <= 1'b0;
        end else if (!primed_q) begin
            // The reset code is a port, so it is loaded after release.
            target_q <= resetCode;
            primed_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (state_d == regbank_pkg::RAMP_IDLE || tick) begin
                timer_q <= 8'h00;
            end else begin
                timer_q <= timer_q + 8'h01;
            end
            if (tick) begin
                case (state_d)
                    regbank_pkg::RAMP_UP: target_q <= target_q + CODE_W'(1);
                    regbank_pkg::RAMP_DOWN: target_q <= target_q - CODE_W'(1);
                    default: target_q <= target_q;
                endcase
            end
        end
    end

    assign targetCode = target_q;
    assign ramping = state_q != regbank_pkg::RAMP_IDLE;
endmodule

//--- logic/buck_converter_config_regs.sv
// Configuration register bank of the step-down converter with slew-limited voltage target.
`timescale 1ns/100ps
// Function
// - Offset 0x00 reads a fixed 8-bit identity code; writes are ignored.
// - Bits 3:2 of offset 0x01 select 20/15/10/5 mV/us slew, reset 10b.
// - Bits 1:0 of offset 0x01 select 0.6/0.8/1.0/1.5 MHz, reset 10b.
// - Offset 0x01 resets to 0x0a; bits 7:4 read as zero.
// - Offset 0x02 holds voltage code; bit 7 read-only; reset 0x28.
module buck_converter_config_regs #(
    parameter logic [7:0] IDENT_CODE = regbank_pkg::IDENT_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access from the serial interface
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regValid,
    // Converter status from the analogue side
    input wire logic [7:0] statusIn,
    // Decoded controls to the converter
    output logic [6:0] voltageTarget,
    output logic voltageRamping,
    output logic [1:0] voltageSlewSelect,
    output logic [3:0] switchFreq,
    output logic [7:0] converterControl,
    output logic [7:0] converterSettings
);
    // ========================================================================
    // Stored registers
    logic [7:0] config_q;
    logic [7:0] vsel_q;
    logic [7:0] ctrl_q;
    logic [7:0] settings_q;
    logic [7:0] status_q;
    logic [7:0] rdata_q;
    logic valid_q;
    // Registered copies of the ramp state and of the frequency decode.
    logic [6:0] vtarget_q;
    logic ramp_q;
    logic [3:0] fsw_q;

    // ========================================================================
    // Address decoding
    wire logic selIdent = regAddr == regbank_pkg::OFS_IDENT;
    wire logic selConfig = regAddr == regbank_pkg::OFS_CONFIG;
    wire logic selVsel = regAddr == regbank_pkg::OFS_VSEL;
    wire logic selCtrl = regAddr == regbank_pkg::OFS_CTRL;
    wire logic selStatus = regAddr == regbank_pkg::OFS_STATUS;
    wire logic selSettings = regAddr == regbank_pkg::OFS_SETTINGS;
    // The identity, the status and unmapped offsets have no write strobe at all.
    wire logic hitConfig = regWrite && selConfig;
    wire logic hitVsel = regWrite && selVsel;
    wire logic hitCtrl = regWrite && selCtrl;
    wire logic hitSettings = regWrite && selSettings;

    // ========================================================================
    // Write masks
    // Reserved config bits forced low; vsel bit 7 keeps its stored value.
    wire logic [7:0] configWr = regWdata & regbank_pkg::CONFIG_WMASK;
    wire logic [7:0] vselWr = (regWdata & regbank_pkg::VSEL_WMASK) |
                              (vsel_q & ~regbank_pkg::VSEL_WMASK);

    // ========================================================================
    // Field extraction
    wire logic [1:0] slewField = config_q[regbank_pkg::SLEW_LSB +: 2];
    wire logic [1:0] freqField = config_q[regbank_pkg::FREQ_LSB +: 2];

    // ========================================================================
    // Field decoding
    // Rounded-down intervals make the 15 mV/us code slightly faster than nominal.
    // Slew code to step interval.
    wire logic [7:0] stepCycles =
        slewField == 2'b00 ? 8'(regbank_pkg::STEP20_CYC) :
        slewField == 2'b01 ? 8'(regbank_pkg::STEP15_CYC) :
        slewField == 2'b10 ? 8'(regbank_pkg::STEP10_CYC) :
                             8'(regbank_pkg::STEP5_CYC);
    wire logic [3:0] fswNext =
        freqField == 2'b00 ? regbank_pkg::FSW_CODE0 :
        freqField == 2'b01 ? regbank_pkg::FSW_CODE1 :
        freqField == 2'b10 ? regbank_pkg::FSW_CODE2 :
                             regbank_pkg::FSW_CODE3;

    // Identity is a constant read path.
    // Unmapped offsets read as zero rather than aliasing a real register.
    wire logic [7:0] readMux =
        selIdent ? IDENT_CODE :
        selConfig ? config_q :
        selVsel ? vsel_q :
        selCtrl ? ctrl_q :
        selStatus ? status_q :
        selSettings ? settings_q : 8'h00;

    wire logic [6:0] rampTarget;
    wire logic rampBusy;

    // ========================================================================
    // Writable registers
    // One short process per register keeps each write strobe local to its own flops.
    // Slew and frequency bits.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_q <= regbank_pkg::RST_CONFIG;
        end else if (hitConfig) begin
            config_q <= configWr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vsel_q <= regbank_pkg::RST_VSEL;
        end else if (hitVsel) begin
            vsel_q <= vselWr;
        end
    end

    // Control and settings bytes are stored whole; their fields act outside this block.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= regbank_pkg::RST_CTRL;
        end else if (hitCtrl) begin
            ctrl_q <= regWdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settings_q <= regbank_pkg::RST_SETTINGS;
        end else if (hitSettings) begin
            settings_q <= regWdata;
        end
    end

    // ========================================================================
    // Status capture
    // Status is resampled every cycle, so a read returns it at most one cycle old.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= regbank_pkg::RST_STATUS;
        end else begin
            status_q <= statusIn;
        end
    end

    // ========================================================================
    // Read answer
    // Read data hold between reads, so a late look by the host still sees the answer.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (regRead) begin
            rdata_q <= readMux;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= regRead;
        end
    end

    // ========================================================================
    // Registered converter controls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vtarget_q <= '0;
        end else begin
            vtarget_q <= rampTarget;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_q <= 1'b0;
        end else begin
            ramp_q <= rampBusy;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fsw_q <= regbank_pkg::FSW_CODE2;
        end else begin
            fsw_q <= fswNext;
        end
    end

    // ========================================================================
    // Voltage ramp
    // The ramp loads its start code one edge after release, as its reset takes constants only.
    // Slew-limited voltage target.
    vid_ramp #(
        .CODE_W(7)
    ) u_ramp (
        .clk(clk),
        .resetn(resetn),
        .resetCode(regbank_pkg::RST_VSEL[6:0]),
        .goalCode(vsel_q[6:0]),
        .stepCycles(stepCycles),
        .targetCode(rampTarget),
        .ramping(rampBusy)
    );

    // ========================================================================
    // Output ports
    assign regRdata = rdata_q;
    assign regValid = valid_q;
    assign voltageTarget = vtarget_q;
    assign voltageRamping = ramp_q;
    assign voltageSlewSelect = config_q[regbank_pkg::SLEW_LSB +: 2];
    assign switchFreq = fsw_q;
    assign converterControl = ctrl_q;
    assign converterSettings = settings_q;
endmodule

//--- tb/regbank_sva.sv
// Assertion checker for the converter register bank ports.
`timescale 1ns/100ps
module regbank_sva #(
    parameter logic [7:0] IDENT_CODE = regbank_pkg::IDENT_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regValid,
    // Decoded controls
    input wire logic [6:0] voltageTarget,
    input wire logic [1:0] voltageSlewSelect,
    input wire logic [3:0] switchFreq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ========================================================================
    // Read path
    property p_ident;
        regRead && regAddr == 8'h00 |=> regRdata == IDENT_CODE;
    endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong");
    property p_cfgrd;
        regRead && regAddr == 8'h01 |=> regRdata[7:4] == 4'h0;
    endproperty
    a_cfgrd: assert property (p_cfgrd) else $error("config top bits set");
    property p_vselrd;
        regRead && regAddr == 8'h02 |=> !regRdata[7];
    endproperty
    a_vselrd: assert property (p_vselrd) else $error("vsel top bit set");
    property p_valid;
        regValid == $past(regRead);
    endproperty
    a_valid: assert property (p_valid) else $error("read answer mistimed");
    property p_rdhold;
        !regRead |=> $stable(regRdata);
    endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    // ========================================================================
    // Decoded fields
    property p_freq3;
        regWrite && regAddr == 8'h01 && regWdata[1:0] == 2'b11 |-> ##2 switchFreq == 4'hf;
    endproperty
    a_freq3: assert property (p_freq3) else $error("frequency code 3 wrong");
    property p_freq0;
        regWrite && regAddr == 8'h01 && regWdata[1:0] == 2'b00 |-> ##2 switchFreq == 4'h6;
    endproperty
    a_freq0: assert property (p_freq0) else $error("frequency code 0 wrong");
    property p_slew;
        regWrite && regAddr == 8'h01 && regWdata[3:2] == 2'b11
            |-> ##[1:2] voltageSlewSelect == 2'b11;
    endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");
    // The fastest rate still needs five cycles per code step.
    property p_step;
        $changed(voltageTarget) && $past(voltageTarget) != 7'h00 |=> $stable(voltageTarget) [*4];
    endproperty
    a_step: assert property (p_step) else $error("target stepped too fast");
endmodule
bind buck_converter_config_regs regbank_sva #(.IDENT_CODE(IDENT_CODE)) regbank_sva_i (
    .clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regValid(regValid),
    .voltageTarget(voltageTarget), .voltageSlewSelect(voltageSlewSelect), .switchFreq(switchFreq)
);

//--- tb/host_model.sv
// Host-side model issuing single-byte register reads and writes.
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic clk,
    // Register access
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regValid
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    // Idle address and data are inverted so a stale value is never mistaken for a request.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        regAddr = ~a;
        d = (regValid === 1'b1) ? regRdata : 8'hxx;
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking testbench for the converter register bank.
`timescale 1ns/100ps
module testbench;
    logic clk;
    logic resetn;
    logic regWrite, regRead, regValid, voltageRamping;
    logic [7:0] regAddr, regWdata, regRdata, statusIn, converterControl, converterSettings, d;
    logic [6:0] voltageTarget;
    logic [1:0] voltageSlewSelect;
    logic [3:0] switchFreq;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] rstVal [7] = '{regbank_pkg::IDENT_DEFAULT, 8'h0a, 8'h28, 8'h0a, 8'h3c, 8'ha4, 8'h00};
    logic [3:0] fsw [4] = '{4'h6, 4'h8, 4'ha, 4'hf};
    buck_converter_config_regs buck_converter_config_regs_i (.clk(clk), .resetn(resetn),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regValid(regValid), .statusIn(statusIn),
        .voltageTarget(voltageTarget), .voltageRamping(voltageRamping),
        .voltageSlewSelect(voltageSlewSelect), .switchFreq(switchFreq),
        .converterControl(converterControl), .converterSettings(converterSettings));
    host_model host_model_i (.clk(clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regValid(regValid));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Counts the cycles between the two code steps of a two-step ramp.
    task automatic step_gap(input logic [1:0] code, input logic [6:0] goal, input int want);
        int n;
        logic [6:0] seen;
        host_model_i.wr(8'h01, {4'h0, code, 2'b10});
        host_model_i.wr(8'h02, {1'b0, goal});
        seen = voltageTarget;
        for (n = 0; n < 100 && voltageTarget === seen; n++) @(negedge clk);
        chk({7'h0, voltageRamping}, 8'h01);
        seen = voltageTarget;
        for (n = 0; n < 100 && voltageTarget === seen; n++) @(negedge clk);
        chk(n[7:0], want[7:0]);
        chk({1'b0, voltageTarget}, {1'b0, goal});
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // The whole sequence needs well under a millisecond.
    initial begin
        #1000000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        statusIn = 8'h3c;
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        // ====================================================================
        // Reset values, including an unmapped offset
        for (int i = 0; i < 7; i++) begin
            host_model_i.rd(i[7:0], d);
            chk(d, rstVal[i]);
        end
        host_model_i.wr(8'h00, 8'hff);
        host_model_i.rd(8'h00, d);
        chk(d, regbank_pkg::IDENT_DEFAULT);
        // ====================================================================
        // Every slew and frequency code, reserved bits written high
        for (int c = 3; c >= 0; c--) begin
            host_model_i.wr(8'h01, {4'hf, c[1:0], c[1:0]});
            host_model_i.rd(8'h01, d);
            chk(d, {4'h0, c[1:0], c[1:0]});
            chk({6'h0, voltageSlewSelect}, {6'h0, c[1:0]});
            chk({4'h0, switchFreq}, {4'h0, fsw[c]});
        end
        // ====================================================================
        // Voltage code change ramps instead of jumping
        host_model_i.wr(8'h02, 8'haa);
        chk({1'b0, voltageTarget}, 8'h28);
        host_model_i.rd(8'h02, d);
        chk(d, 8'h2a);
        for (int k = 0; k < 40 && voltageTarget !== 7'h2a; k++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk({1'b0, voltageTarget}, 8'h2a);
        chk({7'h0, voltageRamping}, 8'h00);
        // ====================================================================
        // Step interval of every slew code
        step_gap(2'b00, 7'h2c, regbank_pkg::STEP20_CYC);
        step_gap(2'b01, 7'h2a, regbank_pkg::STEP15_CYC);
        step_gap(2'b10, 7'h2c, regbank_pkg::STEP10_CYC);
        step_gap(2'b11, 7'h2a, regbank_pkg::STEP5_CYC);
        host_model_i.wr(8'h03, 8'h55);
        host_model_i.wr(8'h05, 8'h33);
        chk(converterControl, 8'h55);
        chk(converterSettings, 8'h33);
        // A second reset in mid-run restores the defaults.
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        host_model_i.rd(8'h01, d);
        chk(d, 8'h0a);
        host_model_i.rd(8'h02, d);
        chk(d, 8'h28);
        chk({1'b0, voltageTarget}, 8'h28);
        chk(converterControl, 8'h0a);
        chk(converterSettings, 8'ha4);
        print_verdict();
    end
endmodule
